// *** logic/pced_pkg.sv ***
// package for the pin change edge detector: register map, field layout, reset values
// assumes a 32-bit classic wishbone slave with word-aligned registers
package pced_pkg;
   // ----------------------------------------------------------------
   // register word offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [5:0] PCED_PORTA_RISE = 6'h00;
   localparam logic [5:0] PCED_PORTA_FALL = 6'h04;
   localparam logic [5:0] PCED_PORTA_FLAG = 6'h08;
   localparam logic [5:0] PCED_PORTB_RISE = 6'h0c;
   localparam logic [5:0] PCED_PORTB_FALL = 6'h10;
   localparam logic [5:0] PCED_PORTB_FLAG = 6'h14;
   localparam logic [5:0] PCED_PORTC_RISE = 6'h18;
   localparam logic [5:0] PCED_PORTC_FALL = 6'h1c;
   localparam logic [5:0] PCED_PORTC_FLAG = 6'h20;
   localparam logic [5:0] PCED_PORTE_RISE = 6'h24;
   localparam logic [5:0] PCED_PORTE_FALL = 6'h28;
   localparam logic [5:0] PCED_PORTE_FLAG = 6'h2c;
   localparam logic [5:0] PCED_CTRL = 6'h30;
   localparam logic [5:0] PCED_STATUS = 6'h34;
   // ----------------------------------------------------------------
   // field layout and reset values
   // ----------------------------------------------------------------
   localparam int PCED_PORT_W = 8;
   localparam logic [7:0] PCED_PORTE_MASK = 8'h08;
   localparam int PCED_MASTER_BIT = 0;
   localparam int PCED_SUMMARY_BIT = 0;
   localparam logic [7:0] PCED_REG_RST = 8'h00;
   localparam logic [31:0] PCED_UNMAPPED_RD = 32'h0000_0000;
   // one port's enable pair
   typedef struct packed {
      logic [7:0] rise;
      logic [7:0] fall;
   } pced_en_t;
endpackage

// *** logic/pced_port.sv ***
// one port of edge detection: previous pin sample, enables and sticky flags
// assumes pins already synchronous to clk_i and bus write strobes one cycle wide
module pced_port
   import pced_pkg::*;
#(
   parameter logic [7:0] IMPL_MASK = 8'hff
) (
   // clock and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // pins
   input wire logic [7:0] pin_i,
   // register writes
   input wire logic we_rise_i,
   input wire logic we_fall_i,
   input wire logic we_flag_i,
   input wire logic [7:0] wdata_i,
   // register state
   output pced_en_t en_o,
   output logic [7:0] flag_o
);
   logic [7:0] prev_r, prev_nxt;
   logic [7:0] rise_r, rise_nxt, fall_r, fall_nxt, flag_r, flag_nxt;
   logic [7:0] hit;

   // next state: enables, edge hits, flags
   always_comb begin
      prev_nxt = pin_i;
      rise_nxt = we_rise_i ? (wdata_i & IMPL_MASK) : rise_r;
      fall_nxt = we_fall_i ? (wdata_i & IMPL_MASK) : fall_r;
      hit = ((pin_i & ~prev_r & rise_r) | (~pin_i & prev_r & fall_r)) & IMPL_MASK;
      flag_nxt = (we_flag_i ? (wdata_i & IMPL_MASK) : flag_r) | hit;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_r <= PCED_REG_RST;
         rise_r <= PCED_REG_RST;
         fall_r <= PCED_REG_RST;
         flag_r <= PCED_REG_RST;
      end else if (ce_i) begin
         prev_r <= prev_nxt;
         rise_r <= rise_nxt;
         fall_r <= fall_nxt;
         flag_r <= flag_nxt;
      end
   end

   assign en_o = '{rise: rise_r, fall: fall_r};
   assign flag_o = flag_r;
endmodule

// *** logic/pced_top.sv ***
// pin change edge detector top: four ports, wishbone register slave, request and wake
// assumes pins synchronous to clk_i; a first sample after reset is not an edge
// (prev resets to zero, so a pin high at release is seen as rising if enabled;
// enables are zero at reset, so that cannot fire).
//
// Function
// - port c rising edges need rise enable
// - port c falling edges need fall enable
// - armed edge sets that pin's flag
// - edge sets pin flag and summary flag
// - flag zero until edge; software writes zero
// - flags read/write, also set by hardware
// - enables and flags reset to zero
// - port e only bit 3, others zero
// - port e pin 3 rising needs enable
// - port e pin 3 falling needs enable
// - port e flag at bit 3
// - master off: flags set, no request
// - summary is OR of all flags
// - edge during flag write stays set
// - master on: change wakes from sleep
module pced_top
   import pced_pkg::*;
(
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [5:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // pins
   input wire logic [7:0] porta_pin_i,
   input wire logic [7:0] portb_pin_i,
   input wire logic [7:0] portc_pin_i,
   input wire logic [7:0] porte_pin_i,
   // to the processor
   output logic change_summary_flag_o,
   output logic irq_o,
   output logic wake_o
);
   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   localparam int NP = 4;
   logic req, wr;
   logic [NP-1:0] we_rise, we_fall, we_flag;
   pced_en_t en [NP];
   logic [7:0] flag [NP];
   logic [7:0] pins [NP];
   logic master_r, master_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic sum_r, sum_nxt, irq_r, irq_nxt, wake_r, wake_nxt;
   logic any_flag;

   // ack only on a fresh strobe so each access gets exactly one ack
   assign req = cyc_i && stb_i && !ack_r;
   assign wr = req && we_i && sel_i[0];
   assign pins[0] = porta_pin_i;
   assign pins[1] = portb_pin_i;
   assign pins[2] = portc_pin_i;
   assign pins[3] = porte_pin_i;

   // write strobes per port register
   always_comb begin
      we_rise = '0;
      we_fall = '0;
      we_flag = '0;
      if (wr) begin
         unique case (adr_i)
            PCED_PORTA_RISE: we_rise[0] = 1'b1;
            PCED_PORTA_FALL: we_fall[0] = 1'b1;
            PCED_PORTA_FLAG: we_flag[0] = 1'b1;
            PCED_PORTB_RISE: we_rise[1] = 1'b1;
            PCED_PORTB_FALL: we_fall[1] = 1'b1;
            PCED_PORTB_FLAG: we_flag[1] = 1'b1;
            PCED_PORTC_RISE: we_rise[2] = 1'b1;
            PCED_PORTC_FALL: we_fall[2] = 1'b1;
            PCED_PORTC_FLAG: we_flag[2] = 1'b1;
            PCED_PORTE_RISE: we_rise[3] = 1'b1;
            PCED_PORTE_FALL: we_fall[3] = 1'b1;
            PCED_PORTE_FLAG: we_flag[3] = 1'b1;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // ports
   // ----------------------------------------------------------------
   // ports a, b, c identical; port e masked to bit 3
   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : g_port
         pced_port #(
            .IMPL_MASK((g == NP - 1) ? PCED_PORTE_MASK : 8'hff)
         ) u_port (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .pin_i(pins[g]),
            .we_rise_i(we_rise[g]),
            .we_fall_i(we_fall[g]),
            .we_flag_i(we_flag[g]),
            .wdata_i(dat_i[7:0]),
            .en_o(en[g]),
            .flag_o(flag[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // control, read data, outputs
   // ----------------------------------------------------------------
   // summary OR across all flags
   assign any_flag = |{flag[0], flag[1], flag[2], flag[3]};

   always_comb begin
      master_nxt = master_r;
      if (wr && adr_i == PCED_CTRL) begin
         master_nxt = dat_i[PCED_MASTER_BIT];
      end
      ack_nxt = req;
      dat_nxt = dat_r;
      if (req && !we_i) begin
         unique case (adr_i)
            PCED_PORTA_RISE: dat_nxt = {24'h0, en[0].rise};
            PCED_PORTA_FALL: dat_nxt = {24'h0, en[0].fall};
            PCED_PORTA_FLAG: dat_nxt = {24'h0, flag[0]};
            PCED_PORTB_RISE: dat_nxt = {24'h0, en[1].rise};
            PCED_PORTB_FALL: dat_nxt = {24'h0, en[1].fall};
            PCED_PORTB_FLAG: dat_nxt = {24'h0, flag[1]};
            PCED_PORTC_RISE: dat_nxt = {24'h0, en[2].rise};
            PCED_PORTC_FALL: dat_nxt = {24'h0, en[2].fall};
            PCED_PORTC_FLAG: dat_nxt = {24'h0, flag[2]};
            // unimplemented port e bits read zero
            PCED_PORTE_RISE: dat_nxt = {24'h0, en[3].rise & PCED_PORTE_MASK};
            PCED_PORTE_FALL: dat_nxt = {24'h0, en[3].fall & PCED_PORTE_MASK};
            PCED_PORTE_FLAG: dat_nxt = {24'h0, flag[3] & PCED_PORTE_MASK};
            PCED_CTRL: dat_nxt = {31'h0, master_r};
            PCED_STATUS: dat_nxt = {31'h0, any_flag};
            default: dat_nxt = PCED_UNMAPPED_RD;
         endcase
      end
      // summary follows flags one cycle later
      sum_nxt = any_flag;
      irq_nxt = any_flag && master_r;
      wake_nxt = any_flag && master_r;
   end

   // registers of the top
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         master_r <= 1'b0;
         ack_r <= 1'b0;
         dat_r <= PCED_UNMAPPED_RD;
         sum_r <= 1'b0;
         irq_r <= 1'b0;
         wake_r <= 1'b0;
      end else if (ce_i) begin
         master_r <= master_nxt;
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         sum_r <= sum_nxt;
         irq_r <= irq_nxt;
         wake_r <= wake_nxt;
      end
   end

   assign dat_o = dat_r;
   assign ack_o = ack_r;
   assign change_summary_flag_o = sum_r;
   assign irq_o = irq_r;
   assign wake_o = wake_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_rise_c;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && portc_pin_i[0] && !$past(portc_pin_i[0]) && en[2].rise[0] && ce_i
       && $past(ce_i)) |=> flag[2][0];
   endproperty
   a_rise_c: assert property (p_rise_c) else $error("rising edge lost on port c");
   property p_fall_c;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && $past(ce_i) && !portc_pin_i[1] && $past(portc_pin_i[1]) && en[2].fall[1])
      |=> flag[2][1];
   endproperty
   a_fall_c: assert property (p_fall_c) else $error("falling edge lost on port c");
   property p_no_set;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && $past(ce_i) && !we_flag[2] && !flag[2][2]
       && portc_pin_i[2] == $past(portc_pin_i[2])) |=> !flag[2][2];
   endproperty
   a_no_set: assert property (p_no_set) else $error("flag set without edge");
   property p_sum;
      @(posedge clk_i) disable iff (rst_i)
      ce_i |=> (change_summary_flag_o == $past(any_flag));
   endproperty
   a_sum: assert property (p_sum) else $error("summary flag mismatch");
   property p_master;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && !master_r) |=> !irq_o;
   endproperty
   a_master: assert property (p_master) else $error("request with master off");
   property p_pe_mask;
      @(posedge clk_i) disable iff (rst_i)
      ((en[3].rise | en[3].fall | flag[3]) & ~PCED_PORTE_MASK) == 8'h00;
   endproperty
   a_pe_mask: assert property (p_pe_mask) else $error("port e unimplemented bit set");
   property p_ack;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && req) |=> ack_o ##1 (!ack_o || !$past(ce_i));
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle");
   property p_wake;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && master_r && any_flag && !wr) |=> wake_o;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on change");
   property p_reset;
      @(posedge clk_i) rst_i |=> (flag[2] == 8'h00 && en[2].rise == 8'h00 && !master_r);
   endproperty
   a_reset: assert property (p_reset) else $error("state not cleared by reset");

   // ----------------------------------------------------------------
   // assertions: other ports, software access, gating
   // ----------------------------------------------------------------
   property p_rise_e;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && $past(ce_i) && porte_pin_i[3] && !$past(porte_pin_i[3]) && en[3].rise[3])
      |=> flag[3][3];
   endproperty
   a_rise_e: assert property (p_rise_e) else $error("port e rise lost");
   property p_fall_e;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && $past(ce_i) && !porte_pin_i[3] && $past(porte_pin_i[3]) && en[3].fall[3])
      |=> flag[3][3];
   endproperty
   a_fall_e: assert property (p_fall_e) else $error("port e fall lost");
   property p_rise_a;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && $past(ce_i) && porta_pin_i[7] && !$past(porta_pin_i[7]) && en[0].rise[7])
      |=> flag[0][7];
   endproperty
   a_rise_a: assert property (p_rise_a) else $error("port a rise lost");
   property p_fall_b;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && $past(ce_i) && !portb_pin_i[4] && $past(portb_pin_i[4]) && en[1].fall[4])
      |=> flag[1][4];
   endproperty
   a_fall_b: assert property (p_fall_b) else $error("port b fall lost");
   property p_set_wins;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && $past(ce_i) && we_flag[2] && portc_pin_i[3] != $past(portc_pin_i[3])
       && (portc_pin_i[3] ? en[2].rise[3] : en[2].fall[3])) |=> flag[2][3];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("edge lost under flag write");
   property p_sum_set;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && flag[2] != 8'h00) |=> change_summary_flag_o;
   endproperty
   a_sum_set: assert property (p_sum_set) else $error("summary not set by flag");
   property p_clear;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && $past(ce_i) && we_flag[1] && dat_i[7:0] == 8'h00
       && portb_pin_i == $past(portb_pin_i)) |=> flag[1] == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("zero write left a flag");
   property p_sw_set;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && we_flag[0]) |=> ((flag[0] & $past(dat_i[7:0])) == $past(dat_i[7:0]));
   endproperty
   a_sw_set: assert property (p_sw_set) else $error("software set lost");
   property p_disarmed;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && !en[2].rise[5] && !en[2].fall[5] && !we_flag[2] && !flag[2][5])
      |=> !flag[2][5];
   endproperty
   a_disarmed: assert property (p_disarmed) else $error("flag set while disarmed");
   property p_pe_read;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && req && !we_i && adr_i == PCED_PORTE_FLAG)
      |=> (dat_o & ~{24'h0, PCED_PORTE_MASK}) == 32'h0000_0000;
   endproperty
   a_pe_read: assert property (p_pe_read) else $error("port e read not masked");
   property p_no_wake;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && !master_r) |=> !wake_o;
   endproperty
   a_no_wake: assert property (p_no_wake) else $error("wake with master off");
endmodule

// *** sim/pced_pins.sv ***
// ----------------------------------------------------------------
// partner model: the pin levels outside the edge detector
// ----------------------------------------------------------------
// assumes the bench hands over wanted levels of ports a, b, c, e
module pced_pins (
   // clock
   input wire logic clk_i,
   // wanted levels, port a in the low byte
   input wire logic [31:0] want_i,
   // pins
   output logic [7:0] porta_o = 8'h00,
   output logic [7:0] portb_o = 8'h00,
   output logic [7:0] portc_o = 8'h00,
   output logic [7:0] porte_o = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   // pins move just after an edge, so the detector sees them already synchronised
   always @(posedge clk_i) begin
      {porte_o, portc_o, portb_o, porta_o} <= want_i;
   end
endmodule

// *** sim/tb.sv ***
// ----------------------------------------------------------------
// testbench for the pin change edge detector
// ----------------------------------------------------------------
// reads queue their expected data; a monitor compares at each read ack
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pced_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] want = 32'h0;
   logic [31:0] rdat;
   logic ack, summ, irq, wake;
   logic [7:0] pa, pb, pc, pe;
   logic [7:0] exp_q[$];
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;
   integer seed = 83;

   pced_top i_dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .porta_pin_i(pa), .portb_pin_i(pb), .portc_pin_i(pc), .porte_pin_i(pe),
      .change_summary_flag_o(summ), .irq_o(irq), .wake_o(wake));
   pced_pins i_pins (.clk_i(clk), .want_i(want), .porta_o(pa), .portb_o(pb),
      .portc_o(pc), .porte_o(pe));

   // free-running 100 MHz clock
   initial begin
      forever #5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // one classic cycle; values read at an edge are those from before it, so no race
   task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 8'h00);
   endtask

   // monitor: oldest queued note against each read answer, plus the hang limit
   always @(posedge clk) begin
      cycles++;
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
         chk("read data", {24'h0, exp_q.pop_front()}, rdat);
      end
      if (cycles == 5000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // every register starts cleared, and a hole reads zero
      for (int i = 0; i < 14; i++) rd(6'(i * 4), 8'h00);
      rd(6'h38, 8'h00);
      // random enables and pin moves on each port in turn
      for (int k = 0; k < 12; k++) begin
         logic [5:0] base;
         logic [7:0] m, r, f, a, b, e;
         logic mst;
         base = 6'((k % 4) * 12);
         m = (k % 4 == 3) ? PCED_PORTE_MASK : 8'hff;
         r = 8'($random(seed));
         f = 8'($random(seed));
         a = 8'($random(seed));
         b = 8'($random(seed));
         mst = 1'($random(seed));
         wb(1'b1, base, 8'h00);
         wb(1'b1, base + 6'h04, 8'h00);
         want[8 * (k % 4) +: 8] <= a;
         // disarmed: the move to a must leave no flag behind
         repeat (3) @(posedge clk);
         wb(1'b1, base, r);
         wb(1'b1, base + 6'h04, f);
         wb(1'b1, PCED_CTRL, {7'h0, mst});
         rd(base, r & m);
         rd(base + 6'h04, f & m);
         want[8 * (k % 4) +: 8] <= b;
         repeat (3) @(posedge clk);
         e = ((r & ~a & b) | (f & a & ~b)) & m;
         rd(base + 6'h08, e);
         rd(PCED_STATUS, {7'h0, |e});
         @(posedge clk);
         chk("summary", {31'h0, |e}, {31'h0, summ});
         chk("irq", {31'h0, mst & (|e)}, {31'h0, irq});
         chk("wake", {31'h0, mst & (|e)}, {31'h0, wake});
         // software may set flags too, and clears them with zero
         wb(1'b1, base + 6'h08, r);
         rd(base + 6'h08, r & m);
         wb(1'b1, base + 6'h08, 8'h00);
         rd(base + 6'h08, 8'h00);
         repeat (2) @(posedge clk);
         chk("summary cleared", 32'h0, {31'h0, summ});
      end
      // a low clock enable holds every flop; the edge lands once it returns
      wb(1'b1, PCED_PORTC_RISE, 8'hff);
      wb(1'b1, PCED_PORTC_FALL, 8'hff);
      ce <= 1'b0;
      want[23:16] <= ~want[23:16];
      repeat (4) @(posedge clk);
      chk("frozen summary", 32'h0, {31'h0, summ});
      ce <= 1'b1;
      rd(PCED_PORTC_FLAG, 8'hff);
      wb(1'b1, PCED_PORTC_FLAG, 8'h00);
      // pins move so that the edge is taken at the same edge as the clearing write
      want[23:16] <= ~want[23:16];
      wb(1'b1, PCED_PORTC_FLAG, 8'h00);
      rd(PCED_PORTC_FLAG, 8'hff);
      wb(1'b1, PCED_PORTC_FLAG, 8'h00);
      // a second reset in mid-run clears enables, flags and master again
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 14; i++) rd(6'(i * 4), 8'h00);
      tally_and_finish();
   end
endmodule
